// file: hw/ptm_ch_if.sv
// Configuration and result bundle between the core and one channel
`timescale 1ns/1ps
`default_nettype none
`include "ptm_consts.svh"

interface ptm_ch_if;
   logic [`PTM_DW-1:0] lim1;
   logic [`PTM_DW-1:0] lim2;
   logic [1:0] lim_en;
   logic swap;
   logic overlay;
   logic filt_en;
   logic [3:0] filt_sel;
   logic load;
   logic [`PTM_DW-1:0] sample;
   logic under;
   logic over;
   logic err;
   logic [`PTM_DW-1:0] value;
   logic [`PTM_DW-1:0] status;

   modport ctl (output lim1, lim2, lim_en, swap, overlay, filt_en,
      filt_sel, load, sample, under, over, err, input value, status);
   modport chan (input lim1, lim2, lim_en, swap, overlay, filt_en,
      filt_sel, load, sample, under, over, err, output value, status);
endinterface

`default_nettype wire

// file: hw/ptm_chan.sv
// One channel: filter, limit evaluation, error and status overlay
`timescale 1ns/1ps
`default_nettype none
`include "ptm_consts.svh"

module ptm_chan
   import ptm_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   ptm_ch_if.chan ch
);
   logic [`PTM_DW-1:0] tap0, tap1, tap2, iir;
   logic [`PTM_DW-1:0] next_iir, next_value, next_status, filt;
   logic [`PTM_DW+1:0] fir_sum;
   logic signed [`PTM_DW:0] diff, step, iir_sum;
   logic [3:0] k;
   logic [1:0] l1, l2;

   function automatic logic [1:0] lim_code(input logic [`PTM_DW-1:0] v,
      input logic [`PTM_DW-1:0] l, input logic en, input logic swap);
      if (!en) return `PTM_LC_OFF;
      if (v == l) return `PTM_LC_EQ;
      if (v > l) return swap ? `PTM_LC_HI : `PTM_LC_LO;
      return swap ? `PTM_LC_LO : `PTM_LC_HI;
   endfunction

   always_comb begin
      // Non-recursive notch: four-tap average
      fir_sum = {2'h0, ch.sample} + {2'h0, tap0} + {2'h0, tap1} +
         {2'h0, tap2};
      // Recursive low-pass, level 1 weakest to level 8 strongest
      if (ch.filt_sel >= `PTM_F_IIR8) begin
         k = 4'h8;
      end else begin
         k = 4'(ch.filt_sel - `PTM_F_IIR1 + 4'h1);
      end
      diff = $signed({1'b0, ch.sample}) - $signed({1'b0, iir});
      step = diff >>> k;
      iir_sum = $signed({1'b0, iir}) + step;
      next_iir = ch.load ? iir_sum[`PTM_DW-1:0] : iir;
      if (!ch.filt_en) begin
         filt = ch.sample;
      end else if (ch.filt_sel == `PTM_F_FIR50 ||
            ch.filt_sel == `PTM_F_FIR60) begin
         filt = fir_sum[`PTM_DW+1:2];
      end else begin
         filt = iir_sum[`PTM_DW-1:0];
      end
      l1 = lim_code(filt, ch.lim1, ch.lim_en[0], ch.swap);
      l2 = lim_code(filt, ch.lim2, ch.lim_en[1], ch.swap);
      next_status = {9'h000, ch.err | ch.under | ch.over, l2, l1,
         ch.over, ch.under};
      if (ch.overlay) begin
         next_status[2:0] = {1'b0, ch.err, ch.under | ch.over};
      end
      next_value = ch.err ? '0 : filt;
      if (!ch.load) begin
         next_status = ch.status;
         next_value = ch.value;
      end
   end

   // Value and status move together on the load pulse
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tap0 <= '0;
         tap1 <= '0;
         tap2 <= '0;
         iir <= '0;
         ch.value <= '0;
         ch.status <= '0;
      end else begin
         if (ch.load) begin
            tap0 <= ch.sample;
            tap1 <= tap0;
            tap2 <= tap1;
         end
         iir <= next_iir;
         ch.value <= next_value;
         ch.status <= next_status;
      end
   end
endmodule

`default_nettype wire

// file: hw/ptm_consts.svh
// Constants for the potentiometer channel processing core
`ifndef PTM_CONSTS_SVH
`define PTM_CONSTS_SVH

`define PTM_NCH 5
`define PTM_DW 16

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PTM_CLK_NS 40
`define PTM_FIR50_NS 625000
`define PTM_FIR60_NS 521000
`define PTM_IIR_NS 500000
`define PTM_DC_LATCH_NS 500
`define PTM_DC_LATCH_CYC (`PTM_DC_LATCH_NS / `PTM_CLK_NS)
`define PTM_DC_SYNC_LAT 3
`define PTM_DC_DLY 4'(`PTM_DC_LATCH_CYC - `PTM_DC_SYNC_LAT)
`define PTM_DIAG_FAST 4'h3
`define PTM_DIAG_SLOW 4'hA

// ----------------------------------------------------------------
// Register map: region haddr[7:5], word index haddr[4:2]
// ----------------------------------------------------------------
`define PTM_R_GLOB 3'h0
`define PTM_R_CHCFG 3'h1
`define PTM_R_LIMIT 3'h2
`define PTM_R_VALUE 3'h3
`define PTM_R_CHST 3'h4
`define PTM_I_CTRL 3'h0
`define PTM_I_DIAG 3'h1
`define PTM_I_STAT 3'h2

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define PTM_CTRL_FILT 0
`define PTM_CTRL_DC 1
`define PTM_CFG_L1EN 0
`define PTM_CFG_L2EN 1
`define PTM_CFG_SWAP 2
`define PTM_CFG_OVL 3
`define PTM_CFG_FSEL 7:4
`define PTM_CFG_RANGE 9:8
`define PTM_CFG_RST 10'h004
`define PTM_DIAG_RST 3'h7
`define PTM_DG_WIPER 0
`define PTM_DG_LOAD 1
`define PTM_DG_SUPPLY 2
`define PTM_F_FIR50 4'h0
`define PTM_F_FIR60 4'h1
`define PTM_F_IIR1 4'h2
`define PTM_F_IIR8 4'h9
`define PTM_LC_OFF 2'h0
`define PTM_LC_HI 2'h1
`define PTM_LC_LO 2'h2
`define PTM_LC_EQ 2'h3

`endif

// file: hw/ptm_core.sv
// Potentiometer measurement core: triggering, diagnostics, AHB-Lite slave
//
// The AHB-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "ptm_consts.svh"

module ptm_core
   import ptm_pkg::*;
#(
   parameter int FIR50_CYC = `PTM_FIR50_NS / `PTM_CLK_NS,
   parameter int FIR60_CYC = `PTM_FIR60_NS / `PTM_CLK_NS,
   parameter int IIR_CYC = `PTM_IIR_NS / `PTM_CLK_NS
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic frame_pulse,
   input wire logic sync1_pin,
   input wire logic supply_fault_pin,
   input wire logic overload_pin,
   output logic adc_start,
   input wire logic adc_valid,
   input wire logic [`PTM_NCH*`PTM_DW-1:0] adc_data,
   input wire logic [`PTM_NCH-1:0] adc_under,
   input wire logic [`PTM_NCH-1:0] adc_over,
   input wire logic [`PTM_NCH-1:0] adc_wiper_open,
   output logic wiper_pulse,
   output logic sample_done
);
   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic ctrl_filt, ctrl_dc, next_filt, next_dc;
   logic [2:0] diag_en, next_diag_en;
   logic [9:0] chcfg [`PTM_NCH];
   logic [`PTM_DW-1:0] val_a [`PTM_NCH];
   logic [`PTM_DW-1:0] st_a [`PTM_NCH];
   logic [31:0] limit [`PTM_NCH];
   logic [`PTM_NCH-1:0] range_nz;
   logic dp_wr;
   logic [2:0] dp_reg, dp_idx;
   logic [31:0] rd_mux;
   logic acc;
   logic [2:0] pin_s;
   logic s1_prev, s1_rise;
   ptm_mode_t mode;
   ptm_seq_t state, next_state;
   logic pend, next_pend, trig;
   logic [3:0] dly, next_dly;
   logic dly_run, next_dly_run;
   logic [15:0] timer, next_timer, period;
   logic [3:0] diag_cnt, next_diag_cnt, diag_int;
   logic diag_due;
   logic [`PTM_NCH-1:0] wiper_err, next_wiper_err, ch_err;
   logic [15:0] conv_cnt, next_conv_cnt;
   logic next_start, next_pulse, next_done, load;

   // ----------------------------------------------------------------
   // Pin synchronisers and mode
   // ----------------------------------------------------------------
   ptm_sync #(.W(3)) u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .d({overload_pin, supply_fault_pin, sync1_pin}),
      .q(pin_s)
   );

   assign s1_rise = pin_s[0] & ~s1_prev;

   always_comb begin
      if (ctrl_filt) begin
         mode = MODE_FREE;
      end else if (ctrl_dc) begin
         mode = MODE_DC;
      end else begin
         mode = MODE_SYNC;
      end
   end

   // Conversion period follows channel one filter setting only
   always_comb begin
      if (chcfg[0][`PTM_CFG_FSEL] == `PTM_F_FIR50) begin
         period = 16'(FIR50_CYC - 1);
      end else if (chcfg[0][`PTM_CFG_FSEL] == `PTM_F_FIR60) begin
         period = 16'(FIR60_CYC - 1);
      end else begin
         period = 16'(IIR_CYC - 1);
      end
   end

   // ----------------------------------------------------------------
   // Trigger and sequencer
   // ----------------------------------------------------------------
   always_comb begin
      for (int n = 0; n < `PTM_NCH; n++) begin
         range_nz[n] = chcfg[n][`PTM_CFG_RANGE] != 2'h0;
      end
      diag_int = (|range_nz) ? `PTM_DIAG_SLOW : `PTM_DIAG_FAST;
      diag_due = diag_en[`PTM_DG_WIPER] && diag_cnt >= diag_int;
      for (int n = 0; n < `PTM_NCH; n++) begin
         ch_err[n] = (diag_en[`PTM_DG_WIPER] & wiper_err[n]) |
            (diag_en[`PTM_DG_LOAD] & pin_s[1]) |
            (diag_en[`PTM_DG_SUPPLY] & pin_s[2]);
      end
   end

   always_comb begin
      trig = 1'b0;
      next_dly = dly;
      next_dly_run = dly_run;
      next_timer = '0;
      unique case (mode)
         MODE_SYNC: begin
            trig = frame_pulse;
            next_dly_run = 1'b0;
         end
         MODE_DC: begin
            if (s1_rise) begin
               next_dly = `PTM_DC_DLY;
               next_dly_run = 1'b1;
            end else if (dly_run) begin
               next_dly = dly - 4'h1;
               if (dly == 4'h0) begin
                  trig = 1'b1;
                  next_dly_run = 1'b0;
               end
            end
         end
         MODE_FREE: begin
            next_dly_run = 1'b0;
            next_timer = timer + 16'h0001;
            if (timer >= period) begin
               trig = 1'b1;
               next_timer = '0;
            end
         end
      endcase
   end

   always_comb begin
      next_state = state;
      next_pend = pend | trig;
      next_start = 1'b0;
      next_pulse = wiper_pulse;
      next_done = 1'b0;
      next_diag_cnt = diag_cnt;
      next_wiper_err = wiper_err;
      next_conv_cnt = conv_cnt;
      load = 1'b0;
      unique case (state)
         SEQ_IDLE: begin
            if (pend) begin
               next_start = 1'b1;
               next_pend = trig;
               next_state = SEQ_CONV;
            end else if (diag_due) begin
               next_start = 1'b1;
               next_pulse = 1'b1;
               next_state = SEQ_DIAG;
            end
         end
         SEQ_CONV: begin
            if (adc_valid) begin
               load = 1'b1;
               next_done = 1'b1;
               next_conv_cnt = conv_cnt + 16'h0001;
               if (diag_cnt != 4'hF) begin
                  next_diag_cnt = diag_cnt + 4'h1;
               end
               next_state = SEQ_IDLE;
            end
         end
         SEQ_DIAG: begin
            // Pulsed conversion only updates wiper state, never values
            if (adc_valid) begin
               next_wiper_err = adc_wiper_open;
               next_pulse = 1'b0;
               next_diag_cnt = '0;
               next_state = SEQ_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= SEQ_IDLE;
         pend <= 1'b0;
         dly <= '0;
         dly_run <= 1'b0;
         timer <= '0;
         diag_cnt <= '0;
         wiper_err <= '0;
         conv_cnt <= '0;
         adc_start <= 1'b0;
         wiper_pulse <= 1'b0;
         sample_done <= 1'b0;
         s1_prev <= 1'b0;
      end else begin
         state <= next_state;
         pend <= next_pend;
         dly <= next_dly;
         dly_run <= next_dly_run;
         timer <= next_timer;
         diag_cnt <= next_diag_cnt;
         wiper_err <= next_wiper_err;
         conv_cnt <= next_conv_cnt;
         adc_start <= next_start;
         wiper_pulse <= next_pulse;
         sample_done <= next_done;
         s1_prev <= pin_s[0];
      end
   end

   // ----------------------------------------------------------------
   // AHB-Lite slave, zero wait states
   // ----------------------------------------------------------------
   assign acc = hsel & hready & htrans[1];

   always_comb begin
      rd_mux = '0;
      unique case (haddr[7:5])
         `PTM_R_GLOB: begin
            if (haddr[4:2] == `PTM_I_CTRL) begin
               rd_mux = {30'h0, ctrl_dc, ctrl_filt};
            end else if (haddr[4:2] == `PTM_I_DIAG) begin
               rd_mux = {29'h0, diag_en};
            end else if (haddr[4:2] == `PTM_I_STAT) begin
               rd_mux = {conv_cnt, 1'b0, pin_s[2:1], wiper_err, 4'h0,
                  state, mode};
            end
         end
         `PTM_R_CHCFG: begin
            if (haddr[4:2] < 3'(`PTM_NCH)) begin
               rd_mux = {22'h0, chcfg[haddr[4:2]]};
            end
         end
         `PTM_R_LIMIT: begin
            if (haddr[4:2] < 3'(`PTM_NCH)) begin
               rd_mux = limit[haddr[4:2]];
            end
         end
         `PTM_R_VALUE: begin
            if (haddr[4:2] < 3'(`PTM_NCH)) begin
               rd_mux = {16'h0, val_a[haddr[4:2]]};
            end
         end
         `PTM_R_CHST: begin
            if (haddr[4:2] < 3'(`PTM_NCH)) begin
               rd_mux = {16'h0, st_a[haddr[4:2]]};
            end
         end
         default: rd_mux = '0;
      endcase
   end

   always_comb begin
      next_filt = ctrl_filt;
      next_dc = ctrl_dc;
      next_diag_en = diag_en;
      if (dp_wr && dp_reg == `PTM_R_GLOB && dp_idx == `PTM_I_CTRL) begin
         // DC refused while filter stays on; filter refused in DC
         next_dc = hwdata[`PTM_CTRL_DC] &
            ~(hwdata[`PTM_CTRL_FILT] & ctrl_filt);
         next_filt = hwdata[`PTM_CTRL_FILT] & ~next_dc;
      end
      if (dp_wr && dp_reg == `PTM_R_GLOB && dp_idx == `PTM_I_DIAG) begin
         next_diag_en = hwdata[2:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_wr <= 1'b0;
         dp_reg <= '0;
         dp_idx <= '0;
         hrdata <= '0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         ctrl_filt <= 1'b0;
         ctrl_dc <= 1'b0;
         diag_en <= `PTM_DIAG_RST;
      end else begin
         dp_wr <= acc & hwrite;
         dp_reg <= haddr[7:5];
         dp_idx <= haddr[4:2];
         hrdata <= (acc & ~hwrite) ? rd_mux : '0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         ctrl_filt <= next_filt;
         ctrl_dc <= next_dc;
         diag_en <= next_diag_en;
      end
   end

   // ----------------------------------------------------------------
   // Per-channel registers and processing
   // ----------------------------------------------------------------
   for (genvar n = 0; n < `PTM_NCH; n++) begin : g_ch
      logic [9:0] next_cfg;
      logic [31:0] next_lim;
      ptm_ch_if chi();

      always_comb begin
         next_cfg = chcfg[n];
         next_lim = limit[n];
         if (dp_wr && dp_idx == 3'(n)) begin
            if (dp_reg == `PTM_R_CHCFG) begin
               next_cfg = hwdata[9:0];
            end
            if (dp_reg == `PTM_R_LIMIT) begin
               next_lim = hwdata;
            end
         end
      end

      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            chcfg[n] <= `PTM_CFG_RST;
            limit[n] <= '0;
         end else begin
            chcfg[n] <= next_cfg;
            limit[n] <= next_lim;
         end
      end

      assign chi.lim1 = limit[n][15:0];
      assign chi.lim2 = limit[n][31:16];
      assign chi.lim_en = {chcfg[n][`PTM_CFG_L2EN], chcfg[n][`PTM_CFG_L1EN]};
      assign chi.swap = chcfg[n][`PTM_CFG_SWAP];
      assign chi.overlay = chcfg[n][`PTM_CFG_OVL];
      assign chi.filt_en = ctrl_filt;
      assign chi.filt_sel = chcfg[0][`PTM_CFG_FSEL];
      assign chi.load = load;
      assign chi.sample = adc_data[n*`PTM_DW +: `PTM_DW];
      assign chi.under = adc_under[n];
      assign chi.over = adc_over[n];
      assign chi.err = ch_err[n];
      assign val_a[n] = chi.value;
      assign st_a[n] = chi.status;

      ptm_chan u_chan (
         .hclk(hclk),
         .hresetn(hresetn),
         .ch(chi.chan)
      );
   end
endmodule

`default_nettype wire

// file: hw/ptm_core_stat_note.sv
// Holds no logic: the status word is assembled inside the core
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: hw/ptm_pkg.sv
// Types shared by the potentiometer channel processing core
package ptm_pkg;

   typedef enum logic [1:0] {
      MODE_SYNC,
      MODE_DC,
      MODE_FREE
   } ptm_mode_t;

   typedef enum logic [1:0] {
      SEQ_IDLE,
      SEQ_CONV,
      SEQ_DIAG
   } ptm_seq_t;

endpackage

// file: hw/ptm_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module ptm_sync #(
   parameter int W = 1
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] ff1;
   logic [W-1:0] ff2;
   logic [W-1:0] ff3;
   logic [W-1:0] next_q;

   // Output follows only where stages two and three agree
   always_comb begin
      next_q = (ff2 & ff3) | (q & (ff2 ^ ff3));
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ff1 <= '0;
         ff2 <= '0;
         ff3 <= '0;
         q <= '0;
      end else begin
         ff1 <= d;
         ff2 <= ff1;
         ff3 <= ff2;
         q <= next_q;
      end
   end
endmodule

`default_nettype wire

// file: verif/ptm_adc_model.sv
// Converter front end answering each start after a random delay
`timescale 1ns/1ps
`default_nettype none

module ptm_adc_model (
   input wire logic hclk,
   input wire logic adc_start,
   input wire logic [79:0] vals,
   output logic adc_valid,
   output logic [79:0] adc_data
);
   int n;

   // ------
   // Data lines toggle outside a result so stale values never match
   // ------
   initial begin
      adc_valid = 1'b0;
      adc_data = '0;
      forever begin
         @(posedge hclk);
         adc_valid <= 1'b0;
         adc_data <= ~adc_data;
         if (adc_start === 1'b1) begin
            n = 1 + $urandom % 8;
            repeat (n) begin
               @(posedge hclk);
               adc_data <= ~adc_data;
            end
            adc_valid <= 1'b1;
            adc_data <= vals;
         end
      end
   end
endmodule

`default_nettype wire

// file: verif/ptm_core_checker.sv
// Port checker for the potentiometer channel processing core
`timescale 1ns/1ps
`default_nettype none

module ptm_core_checker (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic hresp,
   input wire logic adc_start,
   input wire logic adc_valid,
   input wire logic wiper_pulse,
   input wire logic sample_done
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   // ------
   // Bus
   // ------
   chk_ready_high: assert property (hreadyout)
      else $error("bus slave inserted a wait state");
   chk_resp_okay: assert property (!hresp)
      else $error("bus error response");
   chk_rdata_idle: assert property
      (!$past(hsel && hready && htrans[1] && !hwrite) |-> hrdata == 32'h0)
      else $error("read data outside a read data phase");

   // ------
   // Acquisition
   // ------
   chk_done_after: assert property
      (adc_valid && !wiper_pulse |=> sample_done)
      else $error("no sample after conversion result");
   chk_diag_quiet: assert property
      (adc_valid && wiper_pulse |=> !sample_done)
      else $error("diagnostic conversion published a sample");
   chk_done_pulse: assert property (sample_done |=> !sample_done)
      else $error("sample strobe longer than one cycle");
   chk_start_once: assert property
      (adc_start |=> !adc_start until adc_valid)
      else $error("conversion restarted before its result");
   chk_diag_start: assert property
      ($rose(wiper_pulse) |-> adc_start || $past(adc_start))
      else $error("wiper pulse without a conversion start");
endmodule

bind ptm_core ptm_core_checker u_chk (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
   .adc_start(adc_start), .adc_valid(adc_valid),
   .wiper_pulse(wiper_pulse), .sample_done(sample_done));

`default_nettype wire

// file: verif/ptm_core_tb.sv
// Self-checking bench for the potentiometer channel processing core
`timescale 1ns/1ps
`default_nettype none

module ptm_core_tb;
   logic hclk, hresetn, hsel, hwrite, frame_pulse, sync1_pin, wp_q;
   logic hreadyout, hresp, adc_start, adc_valid, wiper_pulse, sample_done;
   logic sup, ovl;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata, r;
   logic [4:0] und, ovr, wo;
   logic [79:0] vals, adc_data;
   logic [15:0] v, l1, l2;
   logic [15:0] ev[5];
   logic [5:0] ec[5];
   logic [9:0] cfg;
   logic [7:0] ra[7] = '{8'h00, 8'h04, 8'h20, 8'h40, 8'h60, 8'h80, 8'hA0};
   logic [31:0] rv[7] = '{32'h0, 32'h7, 32'h4, 32'h0, 32'h0, 32'h0, 32'h0};
   int fails, n_tests, ns, na, n0, i, j, k, c;
   bit wchk;

   ptm_core #(.FIR50_CYC(20), .FIR60_CYC(20), .IIR_CYC(20)) dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .frame_pulse(frame_pulse), .sync1_pin(sync1_pin),
      .supply_fault_pin(sup), .overload_pin(ovl), .adc_start(adc_start),
      .adc_valid(adc_valid), .adc_data(adc_data), .adc_under(und),
      .adc_over(ovr), .adc_wiper_open(wo), .wiper_pulse(wiper_pulse),
      .sample_done(sample_done));
   ptm_adc_model adc (.hclk(hclk), .adc_start(adc_start), .vals(vals),
      .adc_valid(adc_valid), .adc_data(adc_data));

   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end

   // ------
   // Helpers
   // ------
   function automatic logic [1:0] lc(input logic [15:0] x, l,
         input logic en, sw);
      if (!en)
         return 2'h0;
      if (x == l)
         return 2'h3;
      return ((x > l) == sw) ? 2'h1 : 2'h2;
   endfunction

   task automatic chk(input string nm, input logic [31:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("wrong value %s: expected %h, seen %h", nm, exp, got);
      end
   endtask

   task automatic test_done();
      $display("checks %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic hold(input logic s);
      k = 0;
      do begin
         @(posedge hclk);
         k++;
      end while (s && hreadyout !== 1'b1 && k < 50 ||
         !s && sample_done !== 1'b1 && k < 200);
      if (k >= 50 && s || k >= 200) begin
         fails++;
         test_done();
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      hold(1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      hold(1'b1);
      r = hrdata;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge hclk);
      bus(1'b0, a, 32'h0);
   endtask

   task automatic conv();
      frame_pulse <= 1'b1;
      @(posedge hclk);
      frame_pulse <= 1'b0;
      hold(1'b0);
      repeat (4) @(posedge hclk);
   endtask

   always @(posedge hclk) begin
      if (sample_done === 1'b1)
         ns <= ns + 1;
      if (adc_start === 1'b1)
         na <= na + 1;
      if (wiper_pulse === 1'b1 && wp_q !== 1'b1) begin
         if (wchk)
            chk("conversions per wiper check", ns, 3);
         ns <= 0;
      end
      wp_q <= wiper_pulse;
   end

   // ------
   // Main sequence
   // ------
   initial begin
      {hresetn, hsel, hwrite, frame_pulse, sync1_pin, sup, ovl} = '0;
      {htrans, haddr, hwdata, und, ovr, wo, vals} = '0;
      void'($urandom(32'h5e4a83fe));
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      for (i = 0; i < 7; i++) begin
         rd(ra[i]);
         chk("reset value", r, rv[i]);
      end
      bus(1'b1, 8'hA0, 32'hFFFFFFFF);
      rd(8'hA0);
      chk("unmapped", r, 32'h0);
      $display("reset test done");
      wchk = 1'b1;
      for (i = 0; i < 8; i++) begin
         for (j = 0; j < 5; j++) begin
            v = 16'($urandom) & 16'h7FFF;
            l1 = (i % 3 == 0) ? v : 16'($urandom) & 16'h7FFF;
            l2 = (i % 4 == 1) ? v : 16'($urandom) & 16'h7FFF;
            cfg = 10'($urandom) & 10'h007;
            vals[16*j +: 16] <= v;
            ev[j] = v;
            ec[j] = {lc(v, l2, cfg[1], cfg[2]), lc(v, l1, cfg[0], cfg[2]),
               2'h0};
            bus(1'b1, 8'h20 + 8'(4 * j), {22'h0, cfg});
            bus(1'b1, 8'h40 + 8'(4 * j), {l2, l1});
         end
         conv();
         for (j = 0; j < 5; j++) begin
            rd(8'h60 + 8'(4 * j));
            chk("value", r, {16'h0, ev[j]});
            rd(8'h80 + 8'(4 * j));
            chk("status", r, {26'h0, ec[j]});
         end
      end
      $display("limit test done");
      bus(1'b1, 8'h24, 32'h0000000C);
      ovr <= 5'h02;
      conv();
      rd(8'h84);
      chk("overlay over", r & 32'h7, 32'h1);
      ovr <= 5'h00;
      und <= 5'h02;
      conv();
      rd(8'h84);
      chk("overlay under", r & 32'h7, 32'h1);
      und <= 5'h00;
      $display("overlay test done");
      wchk = 1'b0;
      bus(1'b1, 8'h04, 32'h0);
      for (i = 0; i < 2; i++) begin
         bus(1'b1, 8'h00, 32'h3);
         rd(8'h00);
         chk("control in dc", r, 32'h2);
      end
      n0 = na;
      frame_pulse <= 1'b1;
      @(posedge hclk);
      frame_pulse <= 1'b0;
      repeat (20) @(posedge hclk);
      chk("frame ignored in dc", na - n0, 0);
      sync1_pin <= 1'b1;
      c = 0;
      do begin
         @(posedge hclk);
         c++;
      end while (adc_start !== 1'b1 && c < 40);
      chk("sync to latch", 32'(c >= 9 && c <= 18), 32'h1);
      sync1_pin <= 1'b0;
      hold(1'b0);
      bus(1'b1, 8'h00, 32'h0);
      $display("dc test done");
      bus(1'b1, 8'h04, 32'h1);
      wo <= 5'h04;
      vals <= {5{16'h1234}};
      repeat (4) conv();
      rd(8'h68);
      chk("value on error", r, 32'h0);
      rd(8'h88);
      chk("error flag", {31'h0, r[6]}, 32'h1);
      rd(8'h64);
      chk("value beside error", r, 32'h1234);
      wo <= 5'h00;
      sup <= 1'b1;
      bus(1'b1, 8'h04, 32'h2);
      conv();
      rd(8'h60);
      chk("value on supply fault", r, 32'h0);
      sup <= 1'b0;
      ovl <= 1'b1;
      bus(1'b1, 8'h04, 32'h4);
      conv();
      rd(8'h70);
      chk("value on overload", r, 32'h0);
      ovl <= 1'b0;
      $display("diagnostic test done");
      bus(1'b1, 8'h00, 32'h1);
      rd(8'h00);
      chk("filter on", r, 32'h1);
      for (j = 0; j < 10; j += 3) begin
         bus(1'b1, 8'h20, {24'h0, 4'(j), 4'h4});
         hold(1'b0);
         if (j == 0) begin
            rd(8'h64);
            chk("notch steady value", r, 32'h1234);
         end
      end
      $display("free run test done");
      test_done();
   end
endmodule

`default_nettype wire
